// file: async_ctx_ctrl.sv
// control and status flags plus descriptor sequencer of one async context
`timescale 1ns/1ps
`default_nettype none
`include "async_dma_params.svh"

module async_ctx_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic soft_rst_i,
    input wire logic set_we_i,
    input wire logic clr_we_i,
    input wire async_dma_pkg::word_t wdata_i,
    input wire logic ptr_valid_i,
    input wire logic fetch_ack_i,
    input wire logic desc_done_i,
    input wire logic desc_more_i,
    input wire logic fatal_i,
    input wire logic status_we_i,
    input wire logic [4:0] event_code_i,
    input wire logic [2:0] speed_i,
    output async_dma_pkg::word_t ctrl_o,
    output logic fetch_req_o,
    output logic active_o,
    output logic run_o
);
    import async_dma_pkg::*;

    ctx_state_t state_reg;
    ctx_state_t state_next;
    logic run_reg;
    logic wake_reg;
    logic dead_reg;
    logic active_reg;
    logic fetch_reg;
    logic [2:0] spd_reg;
    logic [4:0] evt_reg;
    logic run_set;
    logic run_clr;
    logic wake_set;
    logic start_bad;
    logic fatal_hit;
    logic fetched;

    assign run_set = set_we_i & wdata_i[`RUN_BIT];
    assign run_clr = clr_we_i & wdata_i[`RUN_BIT];
    // the clear address has no effect on wake: software can only set it
    assign wake_set = set_we_i & wdata_i[`WAKE_BIT];
    assign start_bad = run_set & ~run_reg & ~ptr_valid_i;
    assign fatal_hit = (fatal_i & (state_reg != CTX_IDLE)) | start_bad;
    assign fetched = (state_reg == CTX_FETCH) & fetch_ack_i;

    // ============================================================
    // software flags and the hardware-set dead flag
    always_ff @(posedge clk_i) begin
        if (rst_i | soft_rst_i) begin
            run_reg <= 1'b0;
        end else if (run_set) begin
            run_reg <= 1'b1;
        end else if (run_clr) begin
            run_reg <= 1'b0;
        end
    end

    // a wake set in the cycle of a fetch wins so the request is not lost
    always_ff @(posedge clk_i) begin
        if (rst_i | soft_rst_i) begin
            wake_reg <= 1'b0;
        end else if (wake_set) begin
            wake_reg <= 1'b1;
        end else if (fetched) begin
            wake_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i | soft_rst_i) begin
            dead_reg <= 1'b0;
        end else if (fatal_hit) begin
            dead_reg <= 1'b1;
        end else if (run_clr) begin
            dead_reg <= 1'b0;
        end
    end

    // ============================================================
    // completion status from the engine
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            spd_reg <= `SPD_RESET;
            evt_reg <= `EVT_RESET;
        end else if (status_we_i) begin
            spd_reg <= speed_i;
            evt_reg <= event_code_i;
        end
    end

    // ============================================================
    // descriptor sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CTX_IDLE: begin
                if (run_set & ~run_reg & ptr_valid_i) begin
                    state_next = CTX_FETCH;
                end
            end
            CTX_FETCH: begin
                if (fatal_i | run_clr | ~run_reg) begin
                    state_next = CTX_IDLE;
                end else if (fetch_ack_i) begin
                    state_next = CTX_PROCESS;
                end
            end
            CTX_PROCESS: begin
                // a cleared run lets the current descriptor finish first
                if (fatal_i) begin
                    state_next = CTX_IDLE;
                end else if (desc_done_i) begin
                    if (run_clr | ~run_reg) begin
                        state_next = CTX_IDLE;
                    end else if (desc_more_i | wake_reg | wake_set) begin
                        state_next = CTX_FETCH;
                    end else begin
                        state_next = CTX_SUSPEND;
                    end
                end
            end
            CTX_SUSPEND: begin
                if (run_clr | ~run_reg) begin
                    state_next = CTX_IDLE;
                end else if (wake_reg) begin
                    state_next = CTX_FETCH;
                end
            end
            default: begin
                state_next = CTX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i | soft_rst_i) begin
            state_reg <= CTX_IDLE;
            fetch_reg <= 1'b0;
            active_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            fetch_reg <= (state_next == CTX_FETCH);
            active_reg <= (state_next == CTX_FETCH) | (state_next == CTX_PROCESS);
        end
    end

    // reserved ranges stay zero in the read value
    always_comb begin
        ctrl_o = 32'h0000_0000;
        ctrl_o[`RUN_BIT] = run_reg;
        ctrl_o[`WAKE_BIT] = wake_reg;
        ctrl_o[`DEAD_BIT] = dead_reg;
        ctrl_o[`ACTIVE_BIT] = active_reg;
        ctrl_o[`SPD_MSB:`SPD_LSB] = spd_reg;
        ctrl_o[`EVT_MSB:`EVT_LSB] = evt_reg;
    end

    assign fetch_req_o = fetch_reg;
    assign active_o = active_reg;
    assign run_o = run_reg;

endmodule : async_ctx_ctrl
`default_nettype wire

// file: async_dma_context_control.sv
// apb register slave and four asynchronous dma context controls
//
// Operation
// - physical upper bound reads zero, ignores writes
// - reserved control bits always read zero
// - each context has set and clear addresses
// - run changes by hardware only on reset
// - wake is set-only by software, resumes processing
// - wake clears on every descriptor fetch; a wake set in the same cycle wins and stays set
// - fatal error sets read-only dead flag
// - dead clears when software clears run
// - active reads one while processing descriptors
// - speed code field reports packet speed
// - event code holds ack or error code
// - run start fetches at command pointer
// - pointer count zero marks address invalid
`timescale 1ns/1ps
`default_nettype none
`include "async_dma_params.svh"

module async_dma_context_control #(
    parameter int N_CTX = 4,
    parameter int ADDR_W = 12
) (
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic SOFT_RESET_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire async_dma_pkg::word_t PWDATA_I,
    output async_dma_pkg::word_t PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic [N_CTX-1:0] FETCH_ACK_I,
    input wire logic [N_CTX-1:0] DESC_DONE_I,
    input wire logic [N_CTX-1:0] DESC_MORE_I,
    input wire logic [N_CTX-1:0] FATAL_I,
    input wire logic [N_CTX-1:0] STATUS_WE_I,
    input wire logic [5*N_CTX-1:0] EVENT_CODE_I,
    input wire logic [3*N_CTX-1:0] SPEED_I,
    output logic [N_CTX-1:0] FETCH_REQ_O,
    output logic [32*N_CTX-1:0] FETCH_PTR_O,
    output logic [N_CTX-1:0] ACTIVE_O,
    output logic [N_CTX-1:0] RUN_O
);
    import async_dma_pkg::*;

    // ============================================================
    // address map of the contexts, in context order
    localparam logic [ADDR_W-1:0] SET_OFF [4] = '{
        `TX_REQ_CTRL_SET_OFF,
        `TX_RESP_CTRL_SET_OFF,
        `RX_REQ_CTRL_SET_OFF,
        `RX_RESP_CTRL_SET_OFF
    };
    localparam logic [ADDR_W-1:0] CLR_OFF [4] = '{
        `TX_REQ_CTRL_CLR_OFF,
        `TX_RESP_CTRL_CLR_OFF,
        `RX_REQ_CTRL_CLR_OFF,
        `RX_RESP_CTRL_CLR_OFF
    };
    localparam logic [ADDR_W-1:0] PTR_OFF [4] = '{
        `TX_REQ_CMD_PTR_OFF,
        `TX_RESP_CMD_PTR_OFF,
        `RX_REQ_CMD_PTR_OFF,
        `RX_RESP_CMD_PTR_OFF
    };

    // ============================================================
    // bus phases
    logic setup_phase;
    logic access_done;
    logic wr_commit;
    logic pready_reg;
    logic pslverr_reg;
    word_t prdata_reg;

    // decode results
    logic [N_CTX-1:0] hit_set;
    logic [N_CTX-1:0] hit_clr;
    logic [N_CTX-1:0] hit_ptr;
    logic hit_bound;
    logic hit_any;
    word_t rd_value;

    // per-context state
    word_t ctrl_word [N_CTX];
    word_t cmd_ptr_reg [N_CTX];
    logic [N_CTX-1:0] ptr_valid;
    logic [N_CTX-1:0] set_we;
    logic [N_CTX-1:0] clr_we;
    logic [N_CTX-1:0] fetch_req;
    logic [N_CTX-1:0] active;
    logic [N_CTX-1:0] run;

    assign setup_phase = PSEL_I & ~PENABLE_I;
    // the slave always answers in the first access cycle
    assign access_done = PSEL_I & PENABLE_I & pready_reg;
    assign wr_commit = access_done & PWRITE_I;

    // ============================================================
    // address decode
    always_comb begin
        hit_set = '0;
        hit_clr = '0;
        hit_ptr = '0;
        for (int i = 0; i < N_CTX; i++) begin
            hit_set[i] = (PADDR_I == SET_OFF[i]);
            hit_clr[i] = (PADDR_I == CLR_OFF[i]);
            hit_ptr[i] = (PADDR_I == PTR_OFF[i]);
        end
        hit_bound = (PADDR_I == `PHYS_UPPER_BOUND_OFF);
        hit_any = hit_bound | (|hit_set) | (|hit_clr) | (|hit_ptr);
    end

    // the set and clear addresses of a context return the same word
    always_comb begin
        rd_value = 32'h0000_0000;
        if (hit_bound) begin
            rd_value = `PHYS_UPPER_BOUND_VALUE;
        end
        for (int i = 0; i < N_CTX; i++) begin
            if (hit_set[i] | hit_clr[i]) begin
                rd_value = ctrl_word[i];
            end
            if (hit_ptr[i]) begin
                rd_value = cmd_ptr_reg[i];
            end
        end
    end

    // ============================================================
    // apb answer
    // read data is sampled in the setup cycle; a hardware update in the
    // access cycle itself shows on the next read
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= setup_phase;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            pslverr_reg <= 1'b0;
        end else begin
            pslverr_reg <= setup_phase & ~hit_any;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup_phase & ~PWRITE_I) begin
            prdata_reg <= rd_value;
        end else if (access_done) begin
            prdata_reg <= 32'h0000_0000;
        end
    end

    // ============================================================
    // write strobes; the bound location has none so writes vanish
    always_comb begin
        for (int i = 0; i < N_CTX; i++) begin
            set_we[i] = wr_commit & hit_set[i];
            clr_we[i] = wr_commit & hit_clr[i];
        end
    end

    // ============================================================
    // command pointers
    // software may rewrite a pointer while the context runs; the new
    // value reaches FETCH_PTR_O at once; its validity only matters at the next start
    always_ff @(posedge CLOCK_I) begin
        for (int i = 0; i < N_CTX; i++) begin
            if (RESET_I) begin
                cmd_ptr_reg[i] <= `CMD_PTR_RESET;
            end else if (wr_commit & hit_ptr[i]) begin
                cmd_ptr_reg[i] <= PWDATA_I;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < N_CTX; i++) begin
            ptr_valid[i] = (cmd_ptr_reg[i][`PTR_Z_MSB:`PTR_Z_LSB] != `PTR_Z_INVALID);
        end
    end

    // ============================================================
    // context instances
    for (genvar g = 0; g < N_CTX; g++) begin : gen_ctx
        async_ctx_ctrl u_ctx (
            .clk_i(CLOCK_I),
            .rst_i(RESET_I),
            .soft_rst_i(SOFT_RESET_I),
            .set_we_i(set_we[g]),
            .clr_we_i(clr_we[g]),
            .wdata_i(PWDATA_I),
            .ptr_valid_i(ptr_valid[g]),
            .fetch_ack_i(FETCH_ACK_I[g]),
            .desc_done_i(DESC_DONE_I[g]),
            .desc_more_i(DESC_MORE_I[g]),
            .fatal_i(FATAL_I[g]),
            .status_we_i(STATUS_WE_I[g]),
            .event_code_i(EVENT_CODE_I[5*g +: 5]),
            .speed_i(SPEED_I[3*g +: 3]),
            .ctrl_o(ctrl_word[g]),
            .fetch_req_o(fetch_req[g]),
            .active_o(active[g]),
            .run_o(run[g])
        );
    end

    // ============================================================
    // outputs
    // the pointer handed out is the command pointer register as it stands now;
    // the engine follows branch addresses by itself afterwards
    always_comb begin
        for (int i = 0; i < N_CTX; i++) begin
            FETCH_PTR_O[32*i +: 32] = cmd_ptr_reg[i];
        end
    end

    assign PRDATA_O = prdata_reg;
    assign PREADY_O = pready_reg;
    assign PSLVERR_O = pslverr_reg;
    assign FETCH_REQ_O = fetch_req;
    assign ACTIVE_O = active;
    assign RUN_O = run;

endmodule : async_dma_context_control
`default_nettype wire

// file: async_dma_ctx_checker_props.sv
// port checker for the async dma context control block
`timescale 1ns/1ps
`default_nettype none
module async_dma_ctx_checker #(
    parameter int N_CTX = 4,
    parameter int ADDR_W = 12
) (
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic SOFT_RESET_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire async_dma_pkg::word_t PWDATA_I,
    input wire async_dma_pkg::word_t PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic [N_CTX-1:0] FETCH_ACK_I,
    input wire logic [N_CTX-1:0] DESC_DONE_I,
    input wire logic [N_CTX-1:0] DESC_MORE_I,
    input wire logic [N_CTX-1:0] FATAL_I,
    input wire logic [N_CTX-1:0] STATUS_WE_I,
    input wire logic [5*N_CTX-1:0] EVENT_CODE_I,
    input wire logic [3*N_CTX-1:0] SPEED_I,
    input wire logic [N_CTX-1:0] FETCH_REQ_O,
    input wire logic [32*N_CTX-1:0] FETCH_PTR_O,
    input wire logic [N_CTX-1:0] ACTIVE_O,
    input wire logic [N_CTX-1:0] RUN_O
);
    import async_dma_pkg::*;
    // ====================
    // helper logic
    logic wr_done;
    logic ctl_rd;
    logic [N_CTX-1:0] ack_q;
    logic [N_CTX-1:0] fat_q;
    assign wr_done = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O;
    // set and clear words of all four contexts share these low address bits
    assign ctl_rd = PREADY_O & !PWRITE_I & (PADDR_I[8:7] == 2'h3)
        & ((PADDR_I[4:0] == 5'h00) | (PADDR_I[4:0] == 5'h04));
    always_ff @(posedge CLOCK_I) ack_q <= RESET_I ? '0 : (FETCH_ACK_I & FETCH_REQ_O);
    always_ff @(posedge CLOCK_I) fat_q <= RESET_I ? '0 : (FATAL_I & ACTIVE_O);
    // ====================
    // properties
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RESET_I);
    a_ub_zero: assert property (PREADY_O && !PWRITE_I && PADDR_I == 'h120 |->
        PRDATA_O == 32'h0 && !PSLVERR_O) else $error("upper bound read not zero");
    a_rsvd_zero: assert property (ctl_rd |-> (PRDATA_O & 32'hFFFF_6300) == 32'h0)
        else $error("reserved control bits set");
    a_ready_once: assert property (PSEL_I && !PENABLE_I |=> PREADY_O ##1 !PREADY_O)
        else $error("ready not a single access cycle");
    a_run_steady: assert property (!wr_done && !SOFT_RESET_I |=> $stable(RUN_O))
        else $error("run changed without a write");
    a_run_soft: assert property (SOFT_RESET_I |=> RUN_O == '0 && ACTIVE_O == '0)
        else $error("soft reset left a context running");
    a_fetch_active: assert property ((FETCH_REQ_O & ~ACTIVE_O) == '0)
        else $error("fetch without active");
    a_fetch_run: assert property ((FETCH_REQ_O & ~$past(FETCH_REQ_O) & ~RUN_O) == '0)
        else $error("fetch started without run");
    a_ack_drop: assert property (ack_q != '0 |-> (FETCH_REQ_O & ack_q) == '0)
        else $error("fetch request held after ack");
    a_fatal_stop: assert property ((fat_q & ACTIVE_O) == '0)
        else $error("active after fatal error");
endmodule : async_dma_ctx_checker
bind async_dma_context_control async_dma_ctx_checker #(.N_CTX(N_CTX), .ADDR_W(ADDR_W))
    async_dma_ctx_checker_inst (.CLOCK_I(CLOCK_I), .RESET_I(RESET_I),
    .SOFT_RESET_I(SOFT_RESET_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .FETCH_ACK_I(FETCH_ACK_I),
    .DESC_DONE_I(DESC_DONE_I), .DESC_MORE_I(DESC_MORE_I), .FATAL_I(FATAL_I),
    .STATUS_WE_I(STATUS_WE_I), .EVENT_CODE_I(EVENT_CODE_I), .SPEED_I(SPEED_I),
    .FETCH_REQ_O(FETCH_REQ_O), .FETCH_PTR_O(FETCH_PTR_O), .ACTIVE_O(ACTIVE_O),
    .RUN_O(RUN_O));
`default_nettype wire

// file: async_dma_params.svh
// constants of the asynchronous dma context control block
`ifndef ASYNC_DMA_PARAMS_SVH
`define ASYNC_DMA_PARAMS_SVH

// ============================================================
// register offsets (byte addresses)
`define PHYS_UPPER_BOUND_OFF 12'h120
`define TX_REQ_CTRL_SET_OFF 12'h180
`define TX_REQ_CTRL_CLR_OFF 12'h184
`define TX_REQ_CMD_PTR_OFF 12'h19C
`define TX_RESP_CTRL_SET_OFF 12'h1A0
`define TX_RESP_CTRL_CLR_OFF 12'h1A4
`define TX_RESP_CMD_PTR_OFF 12'h1AC
`define RX_REQ_CTRL_SET_OFF 12'h1C0
`define RX_REQ_CTRL_CLR_OFF 12'h1C4
`define RX_REQ_CMD_PTR_OFF 12'h1CC
`define RX_RESP_CTRL_SET_OFF 12'h1E0
`define RX_RESP_CTRL_CLR_OFF 12'h1E4
`define RX_RESP_CMD_PTR_OFF 12'h1EC

// ============================================================
// context control field positions
`define RUN_BIT 15
`define WAKE_BIT 12
`define DEAD_BIT 11
`define ACTIVE_BIT 10
`define SPD_MSB 7
`define SPD_LSB 5
`define EVT_MSB 4
`define EVT_LSB 0
`define PTR_Z_MSB 3
`define PTR_Z_LSB 0

// ============================================================
// reset values
`define PHYS_UPPER_BOUND_VALUE 32'h0000_0000
`define CMD_PTR_RESET 32'h0000_0000
`define SPD_RESET 3'h0
`define EVT_RESET 5'h00
`define PTR_Z_INVALID 4'h0

`endif

// file: async_dma_pkg.sv
// types shared by the asynchronous dma context control block
package async_dma_pkg;

    // ============================================================
    // descriptor sequencer states of one context
    typedef enum logic [1:0] {
        CTX_IDLE,
        CTX_FETCH,
        CTX_PROCESS,
        CTX_SUSPEND
    } ctx_state_t;

    typedef logic [31:0] word_t;

endpackage : async_dma_pkg

// file: tb.sv
// self-checking bench of the async dma context control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import async_dma_pkg::*;
    // ====================
    // signals
    logic clk, rst, srst, psel, pen, pwr, pready, pslverr, er;
    logic [11:0] paddr;
    word_t pwdata, prdata, r, p;
    // engine pulses: 0 ack, 1 status load, 2 done, 3 fatal
    logic [3:0] eng [0:3];
    logic [3:0] more, freq, act, run;
    logic [19:0] evt;
    logic [11:0] spd;
    logic [127:0] fptr;
    logic [2:0] s;
    logic [4:0] ec;
    int n_mismatch, total_checks, seed, g;
    async_dma_context_control async_dma_context_control_inst (.CLOCK_I(clk), .RESET_I(rst),
        .SOFT_RESET_I(srst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .FETCH_ACK_I(eng[0]), .DESC_DONE_I(eng[2]),
        .DESC_MORE_I(more), .FATAL_I(eng[3]), .STATUS_WE_I(eng[1]), .EVENT_CODE_I(evt),
        .SPEED_I(spd), .FETCH_REQ_O(freq), .FETCH_PTR_O(fptr), .ACTIVE_O(act), .RUN_O(run));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ====================
    // tasks
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input word_t seen, input word_t exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    function automatic word_t ctl(input logic rn, wk, dd, ac, input logic [2:0] sp,
        input logic [4:0] ev);
        return {16'h0, rn, 2'b00, wk, dd, ac, 2'b00, sp, ev};
    endfunction : ctl
    function automatic logic [11:0] base(input int c);
        return 12'h180 + 12'(32 * c);
    endfunction : base
    // command pointer words do not sit at one fixed distance from the set word
    function automatic logic [11:0] ptra(input int c);
        case (c)
            0: return 12'h19C;
            1: return 12'h1AC;
            2: return 12'h1CC;
            default: return 12'h1EC;
        endcase
    endfunction : ptra
    // ready is taken at the rising edge while the request still stands
    task automatic apb(input logic w, input logic [11:0] a, input word_t d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        @(posedge clk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                n_mismatch++;
                stop_test();
            end
            @(posedge clk);
        end
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic rdc(input int c, input word_t x);
        apb(1'b0, base(c), 32'h0);
        chk(r, x);
        apb(1'b0, base(c) + 12'h4, 32'h0);
        chk(r, x);
    endtask : rdc
    task automatic pulse(input int k, input int c);
        @(posedge clk);
        eng[k] <= 4'h1 << c;
        @(posedge clk);
        eng[k] <= 4'h0;
    endtask : pulse
    // ====================
    // main sequence
    initial begin
        seed = 56;
        {psel, pen, pwr, srst, more} = '0;
        paddr = '0;
        pwdata = '0;
        for (g = 0; g < 4; g++) eng[g] = 4'h0;
        evt = '0;
        spd = '0;
        rst = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        apb(1'b1, 12'h120, 32'hFFFF_FFFF);
        apb(1'b0, 12'h120, 32'h0);
        chk(r, 32'h0);
        chk(er, 1'b0);
        apb(1'b0, 12'h124, 32'h0);
        chk(er, 1'b1);
        for (g = 0; g < 4; g++) begin
            rdc(g, 32'h0);
            p = $random(seed);
            p[3:0] = 4'h1 + {1'b0, p[2:0]};
            apb(1'b1, ptra(g), p);
            apb(1'b0, ptra(g), 32'h0);
            chk(r, p);
            chk(fptr[32*g +: 32], p);
            apb(1'b1, base(g), 32'h8000 | ($random(seed) & 32'hFFFF_6300));
            @(negedge clk);
            chk({run[g], freq[g], act[g]}, 3'h7);
            rdc(g, ctl(1, 0, 0, 1, 0, 0));
            apb(1'b1, base(g), 32'h1000);
            apb(1'b1, base(g) + 12'h4, 32'h1000);
            rdc(g, ctl(1, 1, 0, 1, 0, 0));
            pulse(0, g);
            rdc(g, ctl(1, 0, 0, 1, 0, 0));
            s = 3'($unsigned($random(seed)) % 3);
            ec = 5'($random(seed));
            evt <= {4{ec}};
            spd <= {4{s}};
            pulse(1, g);
            // odd contexts die while busy, even ones after suspending
            pulse(g[0] ? 3 : 2, g);
            @(negedge clk);
            chk({run[g], act[g]}, 2'h2);
            // a suspended context resumes on wake, then dies while busy
            if (!g[0]) begin
                apb(1'b1, base(g), 32'h1000);
                repeat (2) @(negedge clk);
                chk({freq[g], act[g]}, 2'h3);
                pulse(0, g);
                pulse(3, g);
            end
            rdc(g, ctl(1, 0, 1, 0, s, ec));
            apb(1'b1, base(g) + 12'h4, 32'h8000);
            rdc(g, ctl(0, 0, 0, 0, s, ec));
        end
        apb(1'b1, 12'h1EC, 32'hFFFF_FFF0);
        apb(1'b1, 12'h1E0, 32'h8000);
        @(negedge clk);
        chk(freq[3], 1'b0);
        rdc(3, ctl(1, 0, 1, 0, s, ec));
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk(run, 4'h0);
        rdc(3, ctl(0, 0, 0, 0, s, ec));
        stop_test();
    end
endmodule : tb
`default_nettype wire
